/* File: common/pds_pkg.sv */
/*
 * Types and shared helpers of the pad drive strength bank.
 * Assumes the constants of pds_regs.svh are visible to its users.
 */
package pds_pkg;

    // pad drive strength codes as stored per pin
    typedef enum logic [1:0] {
        PDS_DRV_2MA = 2'h0,
        PDS_DRV_4MA = 2'h1,
        PDS_DRV_8MA = 2'h2,
        PDS_DRV_12MA = 2'h3
    } pds_drive_t;

    typedef logic [15:0] pds_field_t;
    typedef logic [3:0] pds_sel_t;

    // bits with mask set take the new value, the rest keep the old one
    function automatic pds_field_t pds_masked_merge(input pds_field_t old_v,
                                                    input pds_field_t new_v,
                                                    input pds_field_t mask);
        return (old_v & ~mask) | (new_v & mask);
    endfunction

    // one-hot pad select: bit 0 2mA, bit 1 4mA, bit 2 8mA, bit 3 12mA
    function automatic pds_sel_t pds_sel_onehot(input pds_drive_t code);
        pds_sel_t sel;
        sel = 4'h0;
        sel[code] = 1'b1;
        return sel;
    endfunction

endpackage

/* File: common/pds_regs.svh */
/*
 * Register offsets, reset values and field layout of the pad drive
 * strength bank. Assumes byte addressing with one 32-bit word per register.
 */
`ifndef PDS_REGS_SVH
`define PDS_REGS_SVH

`define PDS_OFF_PORT_A 16'h0020
`define PDS_OFF_PORT_B 16'h0024
`define PDS_RESET_PORT_A 16'h0001
`define PDS_RESET_PORT_B 16'h0000
`define PDS_MASK_LSB 16
`define PDS_DATA_W 16
`define PDS_FIELD_W 2
`define PDS_PINS 8
`define PDS_SEL_W 4
`define PDS_READ_UPPER 16'h0000
`define PDS_UNMAPPED_DATA 32'h00000000

`endif

/* File: logic/pds_drive_decode.sv */
/*
 * Registered decode of packed 2-bit drive codes into one-hot pad selects.
 * Assumes the codes come from logic on the same clock.
 */
`timescale 1ns/1ps

module pds_drive_decode
    import pds_pkg::*;
#(
    parameter int PINS = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // packed codes, pin 0 in the low bits
    input wire logic [2*PINS-1:0] codes,
    // one-hot selects, four bits per pin
    output logic [4*PINS-1:0] sel
);

    if (PINS < 1) begin : g_bad_pins
        $error("pds_drive_decode needs at least one pin");
    end

    logic [4*PINS-1:0] sel_q;
    logic [4*PINS-1:0] sel_d;

    always_comb begin
        sel_d = '0;
        for (int p = 0; p < PINS; p++) begin
            sel_d[4*p +: 4] = pds_sel_onehot(pds_drive_t'(codes[2*p +: 2]));
        end
    end

    // one cycle behind the codes; pads see no glitch from the decode
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sel_q <= '0;
        end else begin
            sel_q <= sel_d;
        end
    end

    assign sel = sel_q;

endmodule // pds_drive_decode

/* File: logic/pds_drive_regs.sv */
/*
 * Pad drive strength register bank for two eight-pin always-on ports.
 * Holds two masked-write registers, drives per-pin codes and one-hot pad
 * selects. Assumes a simple strobe bus on ref_clk with reads answered in
 * the following cycle, and pads that accept a registered select.
 */
// The strobed register port is this design's own decision.
`timescale 1ns/1ps

`include "pds_regs.svh"

// Operation
// - The port A register answers at byte offset 0x0020.
// - The port B register answers at byte offset 0x0024 with the port A layout.
// - On a write, a set bit n+16 lets bit n take the written value.
// - On a write, a clear bit n+16 keeps bit n unchanged.
// - Bits 31:16 are write-only masks that are never stored.
// - Each pin has a 2-bit field, pin 7 at bits 15:14 down to pin 0 at bits 1:0.
// - Codes 00, 01, 10, 11 select 2mA, 4mA, 8mA and 12mA.
// - Reset loads port A pin 0 with 1, the 4mA setting.
// - Reset loads every other field of both ports with 0, the 2mA setting.
module pds_drive_regs
    import pds_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // register bus
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [31:0] rd_data,
    // port A drive codes
    output logic [1:0] port_a_pin0_drive,
    output logic [1:0] port_a_pin1_drive,
    output logic [1:0] port_a_pin2_drive,
    output logic [1:0] port_a_pin3_drive,
    output logic [1:0] port_a_pin4_drive,
    output logic [1:0] port_a_pin5_drive,
    output logic [1:0] port_a_pin6_drive,
    output logic [1:0] port_a_pin7_drive,
    // port B drive codes
    output logic [1:0] port_b_pin0_drive,
    output logic [1:0] port_b_pin1_drive,
    output logic [1:0] port_b_pin2_drive,
    output logic [1:0] port_b_pin3_drive,
    output logic [1:0] port_b_pin4_drive,
    output logic [1:0] port_b_pin5_drive,
    output logic [1:0] port_b_pin6_drive,
    output logic [1:0] port_b_pin7_drive,
    // one-hot pad selects, four bits per pin, pin 0 lowest
    output logic [31:0] port_a_drive_sel,
    output logic [31:0] port_b_drive_sel
);

    // the highest offset needs six address bits
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
        $error("pds_drive_regs needs ADDR_W between 6 and 32");
    end

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                      input logic [15:0] offset);
        return a == ADDR_W'(offset);
    endfunction

    // field of one pin, pin n at bits 2n+1:2n
    function automatic logic [`PDS_FIELD_W-1:0] pin_field(input pds_field_t v,
                                                          input int pin);
        return v[pin*`PDS_FIELD_W +: `PDS_FIELD_W];
    endfunction

    logic hit_a;
    logic hit_b;
    logic wr_a;
    logic wr_b;
    pds_field_t wr_value;
    pds_field_t wr_mask;
    pds_field_t port_a_q;
    pds_field_t port_b_q;
    logic [31:0] rd_data_q;
    logic [31:0] rd_data_d;

    // full decode: any other address, aligned or not, is unmapped
    assign hit_a = addr_hit(addr, `PDS_OFF_PORT_A);
    assign hit_b = addr_hit(addr, `PDS_OFF_PORT_B);
    assign wr_a = wr_strobe && hit_a;
    assign wr_b = wr_strobe && hit_b;

    // masks steer the write and are then dropped
    assign wr_value = wr_data[`PDS_DATA_W-1:0];
    assign wr_mask = wr_data[`PDS_MASK_LSB +: `PDS_DATA_W];

    pds_masked_reg #(
        .W(`PDS_DATA_W),
        .RESET_VAL(`PDS_RESET_PORT_A)
    ) u_port_a (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .wr_en(wr_a),
        .wr_value(wr_value),
        .wr_mask(wr_mask),
        .value(port_a_q)
    );

    pds_masked_reg #(
        .W(`PDS_DATA_W),
        .RESET_VAL(`PDS_RESET_PORT_B)
    ) u_port_b (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .wr_en(wr_b),
        .wr_value(wr_value),
        .wr_mask(wr_mask),
        .value(port_b_q)
    );

    pds_drive_decode #(
        .PINS(`PDS_PINS)
    ) u_decode_a (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .codes(port_a_q),
        .sel(port_a_drive_sel)
    );

    pds_drive_decode #(
        .PINS(`PDS_PINS)
    ) u_decode_b (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .codes(port_b_q),
        .sel(port_b_drive_sel)
    );

    // unmapped reads return zero; the bus never waits
    always_comb begin
        rd_data_d = `PDS_UNMAPPED_DATA;
        if (rd_strobe && hit_a) begin
            rd_data_d = {`PDS_READ_UPPER, port_a_q};
        end else if (rd_strobe && hit_b) begin
            rd_data_d = {`PDS_READ_UPPER, port_b_q};
        end
    end

    // read data stands for the cycle after each read strobe cycle, zero otherwise
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data_q <= `PDS_UNMAPPED_DATA;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data = rd_data_q;

    // per-pin fields, pin n at bits 2n+1:2n
    assign port_a_pin0_drive = pin_field(port_a_q, 0);
    assign port_a_pin1_drive = pin_field(port_a_q, 1);
    assign port_a_pin2_drive = pin_field(port_a_q, 2);
    assign port_a_pin3_drive = pin_field(port_a_q, 3);
    assign port_a_pin4_drive = pin_field(port_a_q, 4);
    assign port_a_pin5_drive = pin_field(port_a_q, 5);
    assign port_a_pin6_drive = pin_field(port_a_q, 6);
    assign port_a_pin7_drive = pin_field(port_a_q, 7);
    assign port_b_pin0_drive = pin_field(port_b_q, 0);
    assign port_b_pin1_drive = pin_field(port_b_q, 1);
    assign port_b_pin2_drive = pin_field(port_b_q, 2);
    assign port_b_pin3_drive = pin_field(port_b_q, 3);
    assign port_b_pin4_drive = pin_field(port_b_q, 4);
    assign port_b_pin5_drive = pin_field(port_b_q, 5);
    assign port_b_pin6_drive = pin_field(port_b_q, 6);
    assign port_b_pin7_drive = pin_field(port_b_q, 7);

    // checks

    logic after_reset_q;

    // low during reset and in the first cycle after its release
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            after_reset_q <= 1'b0;
        end else begin
            after_reset_q <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking

    default disable iff (!resetn);

    a_port_a_update: assert property (
        wr_a |=> ((port_a_q ^ $past(wr_value)) & $past(wr_mask)) == 16'h0000
    ) else $error("port A masked bits did not take the written value");

    a_port_b_update: assert property (
        wr_b |=> ((port_b_q ^ $past(wr_value)) & $past(wr_mask)) == 16'h0000
    ) else $error("port B masked bits did not take the written value");

    a_mask_holds_a: assert property (
        wr_a |=> ((port_a_q ^ $past(port_a_q)) & ~$past(wr_mask)) == 16'h0000
    ) else $error("port A unmasked bits changed on write");

    a_mask_holds_b: assert property (
        wr_b |=> ((port_b_q ^ $past(port_b_q)) & ~$past(wr_mask)) == 16'h0000
    ) else $error("port B unmasked bits changed on write");

    a_full_mask_write: assert property (
        wr_a && wr_mask == 16'hFFFF |=> port_a_q == $past(wr_value)
    ) else $error("full-mask write did not load port A");

    a_other_writes: assert property (
        !wr_a && !wr_b |=> port_a_q == $past(port_a_q) && port_b_q == $past(port_b_q)
    ) else $error("register changed without a write to it");

    a_read_port_a: assert property (
        rd_strobe && hit_a |=> rd_data == {16'h0000, $past(port_a_q)}
    ) else $error("port A read returned wrong data");

    a_read_port_b: assert property (
        rd_strobe && hit_b |=> rd_data == {16'h0000, $past(port_b_q)}
    ) else $error("port B read returned wrong data");

    a_read_unmapped: assert property (
        !(rd_strobe && (hit_a || hit_b)) |=> rd_data == 32'h00000000
    ) else $error("read data not zero outside a mapped read");

    a_reset_values: assert property (
        !after_reset_q |-> port_a_q == `PDS_RESET_PORT_A && port_b_q == `PDS_RESET_PORT_B
    ) else $error("drive fields not at reset values after release");

    // resetn is sampled: at the release edge the selects still hold their reset zero
    a_reset_selects: assert property (
        !after_reset_q && resetn |=> port_b_drive_sel == 32'h11111111
    ) else $error("port B selects not 2mA after reset");

    a_reset_sel_a: assert property (
        !after_reset_q && resetn |=> port_a_drive_sel == 32'h11111112
    ) else $error("port A selects not at reset codes after release");

    a_reset_pins: assert property (
        !after_reset_q |-> port_a_pin0_drive == PDS_DRV_4MA
            && port_a_pin7_drive == PDS_DRV_2MA && port_b_pin0_drive == PDS_DRV_2MA
    ) else $error("pin drive codes not at reset values after release");

    a_decode_pin0: assert property (
        resetn |=> port_a_drive_sel[3:0] == 4'h1 << $past(port_a_q[1:0])
    ) else $error("port A pin 0 select does not match its code");

    a_decode_pin7: assert property (
        resetn |=> port_b_drive_sel[31:28] == 4'h1 << $past(port_b_q[15:14])
    ) else $error("port B pin 7 select does not match bits 15:14");

    a_decode_pin3: assert property (
        resetn |=> port_a_drive_sel[15:12] == 4'h1 << $past(port_a_q[7:6])
    ) else $error("port A pin 3 select does not match its code");

    a_decode_b_pin0: assert property (
        resetn |=> port_b_drive_sel[3:0] == 4'h1 << $past(port_b_q[1:0])
    ) else $error("port B pin 0 select does not match its code");

    a_sel_onehot: assert property (
        resetn |=> $onehot(port_a_drive_sel[31:28]) && $onehot(port_b_drive_sel[15:12])
    ) else $error("pad select is not one-hot");

    a_pin_fields: assert property (
        rd_strobe && hit_a |=> rd_data[15:14] == $past(port_a_pin7_drive)
            && rd_data[7:6] == $past(port_a_pin3_drive)
    ) else $error("pin field placed at wrong bits");

    a_port_b_layout: assert property (
        rd_strobe && hit_b |=> rd_data[15:14] == $past(port_b_pin7_drive)
            && rd_data[1:0] == $past(port_b_pin0_drive)
    ) else $error("port B pin fields not at the port A layout");

    a_code_12ma: assert property (
        port_a_pin0_drive == PDS_DRV_12MA |=> port_a_drive_sel[3:0] == 4'h8
    ) else $error("code 11 did not select 12mA");

    a_full_mask_b: assert property (
        wr_b && wr_mask == 16'hFFFF |=> port_b_q == $past(wr_value)
    ) else $error("full-mask write did not load port B");

    a_zero_mask_a: assert property (
        wr_a && wr_mask == 16'h0000 |=> port_a_q == $past(port_a_q)
    ) else $error("empty-mask write changed port A");

    a_read_upper: assert property (
        rd_data[31:16] == 16'h0000
    ) else $error("mask half of read data not zero");

    a_unmapped_write: assert property (
        wr_strobe && !hit_a && !hit_b
            |=> port_a_q == $past(port_a_q) && port_b_q == $past(port_b_q)
    ) else $error("unmapped write changed a register");

    a_write_a_only: assert property (
        wr_a |=> port_b_q == $past(port_b_q)
    ) else $error("port A write changed port B");

    a_read_after_write: assert property (
        (wr_b && wr_mask == 16'hFFFF) ##1 (rd_strobe && hit_b)
            |=> rd_data[15:0] == $past(wr_value, 2)
    ) else $error("read right after a port B write missed the new value");

endmodule // pds_drive_regs

/* File: logic/pds_masked_reg.sv */
/*
 * One masked-write configuration register: a write updates only the bits
 * whose mask bit is set. Assumes a single-cycle write enable on ref_clk.
 */
`timescale 1ns/1ps

module pds_masked_reg
    import pds_pkg::*;
#(
    parameter int W = 16,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // write side
    input wire logic wr_en,
    input wire logic [W-1:0] wr_value,
    input wire logic [W-1:0] wr_mask,
    // stored value
    output logic [W-1:0] value
);

    if (W != 16) begin : g_bad_width
        $error("pds_masked_reg serves only 16-bit fields");
    end

    logic [W-1:0] value_q;
    logic [W-1:0] value_d;

    always_comb begin
        value_d = value_q;
        if (wr_en) begin
            value_d = pds_masked_merge(value_q, wr_value, wr_mask);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            value_q <= RESET_VAL;
        end else begin
            value_q <= value_d;
        end
    end

    assign value = value_q;

endmodule // pds_masked_reg

/* File: testbench/pds_drive_regs_tb.sv */
/*
 * Self-checking bench for the pad drive strength register bank.
 * Assumes the strobe bus of the bank, driven here with no wait states,
 * and read data sampled in the single cycle after the read strobe.
 */
`timescale 1ns/1ps

`include "pds_regs.svh"

module pds_drive_regs_tb
    import pds_pkg::*;
;
    // clock and reset
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    // register bus
    logic [15:0] addr = 16'h0000;
    logic [31:0] wr_data = 32'h00000000;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic [31:0] rd_data;
    // pad side
    wire [15:0] pa_codes;
    wire [15:0] pb_codes;
    logic [31:0] port_a_drive_sel;
    logic [31:0] port_b_drive_sel;

    // expected register contents
    logic [15:0] ma = `PDS_RESET_PORT_A;
    logic [15:0] mb = `PDS_RESET_PORT_B;
    logic [31:0] q;
    int n_mismatch = 0;
    int tests_run = 0;

    always #12.5 ref_clk = ~ref_clk;

    pds_drive_regs #(.ADDR_W(16)) u_dut (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .addr(addr),
        .wr_data(wr_data),
        .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe),
        .rd_data(rd_data),
        .port_a_pin0_drive(pa_codes[1:0]),
        .port_a_pin1_drive(pa_codes[3:2]),
        .port_a_pin2_drive(pa_codes[5:4]),
        .port_a_pin3_drive(pa_codes[7:6]),
        .port_a_pin4_drive(pa_codes[9:8]),
        .port_a_pin5_drive(pa_codes[11:10]),
        .port_a_pin6_drive(pa_codes[13:12]),
        .port_a_pin7_drive(pa_codes[15:14]),
        .port_b_pin0_drive(pb_codes[1:0]),
        .port_b_pin1_drive(pb_codes[3:2]),
        .port_b_pin2_drive(pb_codes[5:4]),
        .port_b_pin3_drive(pb_codes[7:6]),
        .port_b_pin4_drive(pb_codes[9:8]),
        .port_b_pin5_drive(pb_codes[11:10]),
        .port_b_pin6_drive(pb_codes[13:12]),
        .port_b_pin7_drive(pb_codes[15:14]),
        .port_a_drive_sel(port_a_drive_sel),
        .port_b_drive_sel(port_b_drive_sel)
    );

    // one-hot select per pin, worked out independently of the design
    function automatic logic [31:0] sel_of(input logic [15:0] f);
        logic [31:0] s;
        s = 32'h00000000;
        for (int i = 0; i < 8; i++) begin
            s[4*i + f[2*i +: 2]] = 1'b1;
        end
        return s;
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // strobe left high on return so writes can follow each other with no gap
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        addr <= a;
        wr_data <= d;
        wr_strobe <= 1'b1;
        rd_strobe <= 1'b0;
        @(posedge ref_clk);
        if (a === `PDS_OFF_PORT_A) ma = (ma & ~d[31:16]) | (d[15:0] & d[31:16]);
        if (a === `PDS_OFF_PORT_B) mb = (mb & ~d[31:16]) | (d[15:0] & d[31:16]);
    endtask

    // data sampled at the edge closing the answer cycle, before it drops
    task automatic rd(input logic [15:0] a, output logic [31:0] r);
        addr <= a;
        rd_strobe <= 1'b1;
        wr_strobe <= 1'b0;
        @(posedge ref_clk);
        rd_strobe <= 1'b0;
        @(posedge ref_clk);
        r = rd_data;
    endtask

    task automatic check_all;
        logic [31:0] r;
        rd(`PDS_OFF_PORT_A, r);
        chk("port A read", r, {16'h0000, ma});
        rd(`PDS_OFF_PORT_B, r);
        chk("port B read", r, {16'h0000, mb});
        chk("port A codes", {16'h0000, pa_codes}, {16'h0000, ma});
        chk("port B codes", {16'h0000, pb_codes}, {16'h0000, mb});
        chk("port A select", port_a_drive_sel, sel_of(ma));
        chk("port B select", port_b_drive_sel, sel_of(mb));
    endtask

    task automatic close_out;
        $display("checks run %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // the tests need well under 200 cycles
    initial begin
        repeat (2000) @(posedge ref_clk);
        n_mismatch++;
        close_out();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        check_all();
        chk("reset port A", {16'h0000, pa_codes}, 32'h00000001);
        // every code on both ports, back to back
        wr(`PDS_OFF_PORT_A, 32'hFFFFE4E4);
        wr(`PDS_OFF_PORT_B, 32'hFFFF1B1B);
        check_all();
        wr(`PDS_OFF_PORT_A, 32'h0000FFFF);
        rd(`PDS_OFF_PORT_A, q);
        chk("mask clear keeps", q, 32'h0000E4E4);
        // edge bits of the mask: bit 31 clears bit 15, bit 16 sets bit 0
        wr(`PDS_OFF_PORT_A, 32'h80010001);
        rd(`PDS_OFF_PORT_A, q);
        chk("edge mask bits", q, 32'h000064E5);
        // port A pin 0 to the 12mA code, checked again by the later selects
        wr(`PDS_OFF_PORT_A, 32'h00030003);
        rd(`PDS_OFF_PORT_A, q);
        chk("pin 0 strongest", q, 32'h000064E7);
        // unmapped neighbours must not alias onto either register
        wr(16'h0028, 32'hFFFFFFFF);
        wr(16'h0021, 32'hFFFFFFFF);
        wr(16'h0004, 32'hFFFFFFFF);
        rd(16'h0028, q);
        chk("unmapped read", q, 32'h00000000);
        check_all();
        // read right after a write sees the new value
        wr(`PDS_OFF_PORT_B, 32'hFFFF5A5A);
        rd(`PDS_OFF_PORT_B, q);
        chk("write then read", q, 32'h00005A5A);
        check_all();
        // second reset in mid-run
        resetn <= 1'b0;
        ma = `PDS_RESET_PORT_A;
        mb = `PDS_RESET_PORT_B;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        check_all();
        close_out();
    end

endmodule // pds_drive_regs_tb
